// File: verilog/sdram_mode_pkg.sv
// Package for the SDRAM mode and extended mode registers and burst column sequencer.
// Assumes a single 20 MHz clock shared with the memory controller pins.
`default_nettype none
package sdram_mode_pkg;

  // ==========================================================================
  // Sizes
  localparam int ADDR_W = 12;
  localparam int COL_W = 9;
  localparam int MAX_LAT = 3;
  localparam logic [8:0] PAGE_MASK_X16 = 9'h1FF;
  localparam logic [8:0] PAGE_MASK_X32 = 9'h0FF;

  // ==========================================================================
  // Field codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] LAT_1 = 3'h1;
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;
  localparam logic [1:0] BANK_BASE = 2'h0;
  localparam logic [1:0] BANK_EXT = 2'h2;

  // ==========================================================================
  // Reset values; the part itself powers up unknown, so these are chosen stand-ins.
  localparam logic [11:0] BASE_MODE_RESET = 12'h022;
  localparam logic [11:0] EXT_MODE_RESET = 12'h000;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
  } sdram_cmd_t;

  typedef struct packed {
    logic [1:0] reserved;
    logic write_burst_select_bit;
    logic op_mode_high_bit;
    logic op_mode_low_bit;
    logic [2:0] read_latency_field;
    logic burst_order_bit;
    logic [2:0] burst_len_field;
  } base_mode_t;

  typedef struct packed {
    logic [6:0] rfu;
    logic temp_setting_high_bit;
    logic temp_setting_low_bit;
    logic [2:0] partial_array_refresh;
  } ext_mode_t;

  typedef enum logic {SEQ_IDLE, SEQ_BURST} seq_state_t;

endpackage
`default_nettype wire

// File: verilog/lat_taps.sv
// Shift line that delays a one-bit beat marker by up to DEPTH clocks.
// Tap 0 is the input itself; tap k is the input delayed k clocks.
`timescale 1ns/1ps
`default_nettype none
module lat_taps #(
  parameter int DEPTH = 3
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_bit,
  output logic [DEPTH:0] o_taps
);

  logic [DEPTH:1] pipe_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= {pipe_q[DEPTH-1:1], i_bit};
    end
  end

  assign o_taps = {pipe_q, i_bit};

endmodule
`default_nettype wire

// File: verilog/sdram_mode_burst_sequencer.sv
// Mode and extended mode registers of a quad-bank SDRAM with the burst
// column sequencer and read latency timing that those registers steer.
// Assumes command pins are synchronous to i_clk and sampled on its edge.
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_burst_sequencer
  import sdram_mode_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire sdram_cmd_t i_cmd,
  input wire logic i_org_x32,
  output logic [COL_W-1:0] o_col,
  output logic o_beat_valid,
  output logic o_beat_write,
  output logic o_dq_oe,
  output logic o_rd_data_valid,
  output logic [1:0] o_temp_setting,
  output logic [2:0] o_partial_array_refresh,
  output logic o_mode_reserved
);

  // ==========================================================================
  // Command decode
  wire sel = ~i_cmd.cs_n;
  wire is_rw = sel & i_cmd.ras_n & ~i_cmd.cas_n;
  wire is_wr = is_rw & ~i_cmd.we_n;
  wire is_rd = is_rw & i_cmd.we_n;
  wire is_term = sel & i_cmd.ras_n & i_cmd.cas_n & ~i_cmd.we_n;
  wire is_lmr = sel & ~i_cmd.ras_n & ~i_cmd.cas_n & ~i_cmd.we_n;
  wire ld_base = is_lmr & (i_cmd.ba == BANK_BASE);
  wire ld_ext = is_lmr & (i_cmd.ba == BANK_EXT);

  // ==========================================================================
  // Mode registers
  base_mode_t base_q;
  ext_mode_t ext_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      base_q <= base_mode_t'(BASE_MODE_RESET);
      ext_q <= ext_mode_t'(EXT_MODE_RESET);
    end else begin
      if (ld_base) begin
        base_q <= base_mode_t'(i_cmd.addr);
      end
      if (ld_ext) begin
        ext_q <= ext_mode_t'(i_cmd.addr);
      end
    end
  end

  assign o_temp_setting = {ext_q.temp_setting_high_bit, ext_q.temp_setting_low_bit};
  assign o_partial_array_refresh = ext_q.partial_array_refresh;

  // ==========================================================================
  // Field decode; reserved length codes fall back to a single access so a
  // bad load never runs a burst off into a neighbouring block.
  wire [2:0] bl = base_q.burst_len_field;
  wire [2:0] lat = base_q.read_latency_field;
  wire bl_page = (bl == BL_PAGE);
  wire bl_ok = (bl == BL_1) | (bl == BL_2) | (bl == BL_4) | (bl == BL_8) | bl_page;
  wire lat_ok = (lat == LAT_1) | (lat == LAT_2) | (lat == LAT_3);
  wire [8:0] page_mask = i_org_x32 ? PAGE_MASK_X32 : PAGE_MASK_X16;
  wire [8:0] blk_mask = (bl == BL_2) ? 9'h001 : (bl == BL_4) ? 9'h003 :
                        (bl == BL_8) ? 9'h007 : 9'h000;
  wire single_wr = is_wr & base_q.write_burst_select_bit;
  wire [8:0] len_m1_d = single_wr ? 9'h000 : bl_page ? page_mask : blk_mask;
  wire page_d = bl_page & ~single_wr;
  assign o_mode_reserved = ~bl_ok | ~lat_ok | base_q.op_mode_low_bit |
                           base_q.op_mode_high_bit | (|base_q.reserved) |
                           (bl_page & base_q.burst_order_bit) | (|ext_q.rfu);

  // ==========================================================================
  // Burst column sequencer
  seq_state_t state_q;
  logic [8:0] col_q;
  logic [8:0] cnt_q;
  logic [8:0] len_m1_q;
  logic [2:0] start_off_q;
  logic inter_q;
  logic page_q;
  logic wr_q;

  wire [8:0] cnt1 = 9'(cnt_q + 9'h001);
  wire [2:0] off_seq = 3'(start_off_q + cnt1[2:0]);
  wire [2:0] off_int = start_off_q ^ cnt1[2:0];
  wire [2:0] off_next = (inter_q ? off_int : off_seq) & len_m1_q[2:0];
  wire [8:0] col_blk = (col_q & ~len_m1_q) | {6'h00, off_next};
  wire [8:0] col_page = 9'(col_q + 9'h001) & page_mask;
  wire last = ~page_q & (cnt_q == len_m1_q);
  wire [8:0] start_col = i_cmd.addr[8:0] & page_mask;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= SEQ_IDLE;
      col_q <= '0;
      cnt_q <= '0;
      len_m1_q <= '0;
      start_off_q <= '0;
      inter_q <= 1'h0;
      page_q <= 1'h0;
      wr_q <= 1'h0;
    end else if (is_rw) begin
      state_q <= SEQ_BURST;
      col_q <= start_col;
      cnt_q <= '0;
      len_m1_q <= len_m1_d;
      start_off_q <= start_col[2:0];
      inter_q <= base_q.burst_order_bit & ~bl_page;
      page_q <= page_d;
      wr_q <= is_wr;
    end else begin
      unique case (state_q)
        SEQ_IDLE: begin
          cnt_q <= '0;
        end
        SEQ_BURST: begin
          if (is_term || last) begin
            state_q <= SEQ_IDLE;
          end else begin
            cnt_q <= cnt1;
            col_q <= page_q ? col_page : col_blk;
          end
        end
      endcase
    end
  end

  assign o_col = col_q;
  assign o_beat_valid = (state_q == SEQ_BURST);
  assign o_beat_write = o_beat_valid & wr_q;

  // ==========================================================================
  // Read latency; reserved latency codes act as three, the safest timing.
  logic [MAX_LAT:0] taps;
  wire [1:0] lat_m = lat_ok ? lat[1:0] : 2'h3;

  lat_taps #(.DEPTH(MAX_LAT)) u_lat_taps (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_bit(o_beat_valid & ~wr_q),
    .o_taps(taps)
  );

  assign o_dq_oe = taps[lat_m - 2'h1];
  assign o_rd_data_valid = taps[lat_m];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  AST_RD_LAT1: assert property (is_rd && lat == LAT_1 |-> ##1 o_dq_oe ##1 o_rd_data_valid)
    else $error("Latency one read timing wrong.");
  // A read that lands in a running burst still has the old beats in the pipe,
  // so the quiet lead-in is only checked when the pipe was empty.
  AST_RD_LAT2: assert property (is_rd && lat == LAT_2 && !o_beat_valid |->
      ##1 !o_dq_oe ##1 o_dq_oe ##1 o_rd_data_valid)
    else $error("Latency two read timing wrong.");
  AST_RD_LAT3: assert property (is_rd && lat == LAT_3 && !o_beat_valid &&
      !$past(o_beat_valid) |-> ##2 !o_rd_data_valid ##1 o_dq_oe ##1 o_rd_data_valid)
    else $error("Latency three read timing wrong.");
  AST_LOAD_BASE: assert property (ld_base |=> base_q == $past(i_cmd.addr))
    else $error("Base mode load missed.");
  AST_LOAD_EXT: assert property (ld_ext |=> o_temp_setting == $past(i_cmd.addr[4:3]))
    else $error("Extended mode load or temperature setting wrong.");
  AST_LOAD_RSV: assert property (is_lmr && !ld_base && !ld_ext |=>
      $stable(base_q) && $stable(ext_q))
    else $error("Reserved bank select changed a mode register.");
  AST_BL1_SINGLE: assert property (is_rw && bl == BL_1 ##1 !is_rw |-> ##1 !o_beat_valid)
    else $error("Length one burst ran past one beat.");
  AST_WR_SINGLE: assert property (is_wr && base_q.write_burst_select_bit ##1 !is_rw |->
      ##1 !o_beat_valid)
    else $error("Single write burst ran past one beat.");
  AST_WRAP_BLOCK: assert property (o_beat_valid && !page_q && $past(o_beat_valid) &&
      !$past(is_rw) |-> (o_col & ~len_m1_q) == ($past(o_col) & ~len_m1_q))
    else $error("Burst left its block.");
  AST_INTERLEAVE8: assert property (is_rd && bl == BL_8 && base_q.burst_order_bit &&
      i_cmd.addr[2:0] == 3'h5 ##1 (!is_rw && !is_term)[*3] |-> ##1 o_col[2:0] == 3'h6)
    else $error("Interleaved order wrong.");
  AST_SEQ4: assert property (is_rd && bl == BL_4 && !base_q.burst_order_bit &&
      i_cmd.addr[1:0] == 2'h1 ##1 (!is_rw && !is_term)[*2] |-> ##1 o_col[1:0] == 2'h3)
    else $error("Sequential order wrong.");
  AST_BL2_WRAP: assert property (is_rd && bl == BL_2 && i_cmd.addr[0]
      ##1 (!is_rw && !is_term) |-> ##1 o_col[0] == 1'h0 && o_col[8:1] == $past(o_col[8:1]))
    else $error("Length two wrap wrong.");
  AST_PAGE_STEP: assert property (o_beat_valid && page_q && $past(o_beat_valid) &&
      !$past(is_rw) |-> o_col == (9'($past(o_col) + 9'h001) & page_mask))
    else $error("Full page step wrong.");
  AST_ORDER_SEL: assert property (is_rw |=>
      inter_q == ($past(base_q.burst_order_bit) && !$past(bl_page)))
    else $error("Burst order not taken from mode.");
  AST_OFFSET_BL8: assert property (is_rd && bl == BL_8 ##1 !is_rw |->
      ##1 o_col[8:3] == $past(o_col[8:3]))
    else $error("Length eight block wrong.");
  AST_TERM_END: assert property (o_beat_valid && is_term |=> !o_beat_valid)
    else $error("Burst terminate did not end the burst.");
  AST_RSV_LEN: assert property (is_rw && !bl_ok ##1 !is_rw |-> ##1 !o_beat_valid)
    else $error("Reserved length code ran more than one beat.");
  AST_RSV_LAT: assert property (is_rd && !lat_ok && !o_beat_valid && !$past(o_beat_valid)
      |-> ##2 !o_rd_data_valid ##1 o_dq_oe ##1 o_rd_data_valid)
    else $error("Reserved latency code did not act as three.");

  COV_RD_LAT3: cover property (is_rd && lat == LAT_3 ##4 o_rd_data_valid);
  COV_PAGE_TERM: cover property (o_beat_valid && page_q && is_term);
  COV_EXT_LOAD: cover property (ld_ext);
  COV_WR_SINGLE: cover property (is_wr && base_q.write_burst_select_bit && bl == BL_8);
  COV_RESTART: cover property (o_beat_valid && is_rd);

endmodule
`default_nettype wire

// File: sim/sdram_ctrl_model.sv
// Controller-side model that drives the SDRAM command pins.
// Assumes one clock shared with the device; pins change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model
  import sdram_mode_pkg::*;
(
  input wire logic i_clk,
  output var sdram_cmd_t o_cmd
);
  // ==========================================================================
  // Command pins
  // Between commands the pins carry a NOP, so nothing stray is registered.
  localparam sdram_cmd_t cmd_nop = '{1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 12'h000};

  initial o_cmd = cmd_nop;

  // One command for exactly one edge, then back to a NOP.
  // Loads are only sent while no burst runs, with at least one idle cycle after each.
  task automatic issue(input logic [3:0] pins, input logic [1:0] ba, input logic [11:0] addr);
    @(posedge i_clk);
    o_cmd <= '{pins[3], pins[2], pins[1], pins[0], ba, addr};
    @(posedge i_clk);
    o_cmd <= cmd_nop;
  endtask
endmodule
`default_nettype wire

// File: sim/test_sdram_mode_burst_sequencer.sv
// Self-checking bench for the mode registers and burst column sequencer.
// Assumes the controller model drives all command pins at rising edges.
`timescale 1ns/1ps
`default_nettype none
module test_sdram_mode_burst_sequencer
  import sdram_mode_pkg::*;
();
  // ==========================================================================
  // Signals and parts
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_org_x32 = 1'b0;
  sdram_cmd_t cmd;
  logic [8:0] col;
  logic beat_valid, beat_write, dq_oe, rd_valid, mode_rsv;
  logic [1:0] temp;
  logic [2:0] par;
  int err_total = 0;
  int total_checks = 0;
  typedef struct packed {logic [11:0] mode; logic [8:0] start; logic wr;} row_t;
  row_t rows [9] = '{'{12'h011, 9'h005, 1'b0}, '{12'h022, 9'h001, 1'b0},
    '{12'h03A, 9'h00D, 1'b0}, '{12'h02B, 9'h105, 1'b0}, '{12'h013, 9'h00E, 1'b0},
    '{12'h028, 9'h123, 1'b0}, '{12'h222, 9'h006, 1'b1}, '{12'h023, 9'h0F9, 1'b1},
    '{12'h232, 9'h00B, 1'b0}};

  always #25 i_clk = ~i_clk;

  sdram_ctrl_model ctrl (.i_clk(i_clk), .o_cmd(cmd));

  sdram_mode_burst_sequencer uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd(cmd),
    .i_org_x32(i_org_x32), .o_col(col), .o_beat_valid(beat_valid), .o_beat_write(beat_write),
    .o_dq_oe(dq_oe), .o_rd_data_valid(rd_valid), .o_temp_setting(temp),
    .o_partial_array_refresh(par), .o_mode_reserved(mode_rsv));

  // ==========================================================================
  // Helpers
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected columns come from the order rules, never from the design.
  task automatic burst(input row_t r);
    int len;
    int lat;
    logic [8:0] msk;
    logic [8:0] c;
    len = 1 << r.mode[1:0];
    lat = int'(r.mode[6:4]);
    if (r.wr && r.mode[9]) len = 1;
    msk = 9'(len - 1);
    ctrl.issue(4'h0, BANK_BASE, r.mode);
    ctrl.issue(r.wr ? 4'h4 : 4'h5, 2'h0, {3'h0, r.start});
    for (int k = 0; k < len + 4; k++) begin
      if (k > 0) @(posedge i_clk);
      #1;
      c = r.mode[3] ? r.start ^ 9'(k) : (r.start & ~msk) | (9'(r.start + k) & msk);
      check("beat_valid", 9'(k < len), 9'(beat_valid));
      if (k < len) check("col", c, col);
      check("beat_write", 9'(r.wr && k < len), 9'(beat_write));
      check("dq_oe", 9'(!r.wr && k + 1 >= lat && k + 1 - lat < len), 9'(dq_oe));
      check("rd_valid", 9'(!r.wr && k >= lat && k - lat < len), 9'(rd_valid));
      check("mode_reserved", 9'h000, 9'(mode_rsv));
    end
  endtask

  task automatic conclude();
    $display("Checks made %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1;
    check("reset_state", 9'h000, {beat_valid, dq_oe, rd_valid, temp, par, mode_rsv});
    for (int i = 0; i < 9; i++) burst(rows[i]);
    // Full page on the 32-bit organisation wraps inside 256 columns.
    @(posedge i_clk) i_org_x32 <= 1'b1;
    ctrl.issue(4'h0, BANK_BASE, 12'h027);
    ctrl.issue(4'h5, 2'h0, 12'h1FE);
    for (int k = 0; k < 4; k++) begin
      if (k > 0) @(posedge i_clk);
      #1 check("page_col", 9'((k + 254) % 256), col);
    end
    ctrl.issue(4'h6, 2'h0, 12'h000);
    @(posedge i_clk) #1 check("page_end", 9'h000, 9'(beat_valid));
    ctrl.issue(4'h0, BANK_EXT, 12'h01D);
    @(posedge i_clk) #1 check("temp", 9'h003, 9'(temp));
    check("par", 9'h005, 9'(par));
    // Reserved bank selects must leave both registers untouched.
    ctrl.issue(4'h0, 2'h1, 12'h000);
    ctrl.issue(4'h0, 2'h3, 12'h008);
    @(posedge i_clk) #1 check("temp_kept", 9'h003, 9'(temp));
    check("rsv_clear", 9'h000, 9'(mode_rsv));
    ctrl.issue(4'h0, BANK_BASE, 12'h0A2);
    @(posedge i_clk) #1 check("rsv_flag", 9'h001, 9'(mode_rsv));
    // Reserved length and latency codes fall back to one beat at latency three.
    ctrl.issue(4'h0, BANK_BASE, 12'h004);
    ctrl.issue(4'h5, 2'h0, 12'h013);
    for (int k = 0; k < 5; k++) begin
      if (k > 0) @(posedge i_clk);
      #1;
      if (k == 0) check("rsv_col", 9'h013, col);
      check("rsv_len_flag", 9'h001, 9'(mode_rsv));
      check("rsv_beat", 9'(k == 0), 9'(beat_valid));
      check("rsv_oe", 9'(k == 2), 9'(dq_oe));
      check("rsv_valid", 9'(k == 3), 9'(rd_valid));
    end
    // A read inside a running burst restarts the sequence at once.
    ctrl.issue(4'h0, BANK_BASE, 12'h022);
    ctrl.issue(4'h5, 2'h0, 12'h010);
    ctrl.issue(4'h5, 2'h0, 12'h021);
    for (int k = 0; k < 7; k++) begin
      if (k > 0) @(posedge i_clk);
      #1;
      if (k < 4) check("restart_col", 9'h020 | 9'((k + 1) % 4), col);
      check("restart_valid", 9'(k < 4), 9'(beat_valid));
      check("restart_rd", 9'(k < 6), 9'(rd_valid));
    end
    // A reset in mid-burst drops the beats and restores both registers.
    ctrl.issue(4'h5, 2'h0, 12'h000);
    @(posedge i_clk) i_reset_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1 check("mid_reset", 9'h000, {beat_valid, dq_oe, rd_valid, temp, par, mode_rsv});
    ctrl.issue(4'h5, 2'h0, 12'h003);
    for (int k = 0; k < 5; k++) begin
      if (k > 0) @(posedge i_clk);
      #1;
      if (k < 4) check("reset_col", 9'((k + 3) % 4), col);
      check("reset_len", 9'(k < 4), 9'(beat_valid));
      check("reset_lat", 9'(k >= 2), 9'(rd_valid));
    end
    conclude();
  end
endmodule
`default_nettype wire
